//--- rtl/cce_exec.sv
// Execution unit for call, watchdog clear, clear, complement and decrement
// Functional notes
// - Call pushes address of following instruction onto the return stack
// - Call loads its eleven-bit literal into program counter bits 10..0
// - Call fills program counter bits 12..11 from latch bits 4..3
// - Call takes two cycles and leaves all status flags unchanged
// - Watchdog clear zeroes the watchdog counter and its prescaler
// - Watchdog clear sets the timeout and power-down flags
// - Register clear writes zero to the file register and sets zero flag
// - Working clear writes zero to working register and sets zero flag
// - Invert complements file register, stored to working or file by dest bit
// - Decrement stores file minus one by dest bit, updates only zero flag
// - Decrement-skip stores file minus one by dest bit, flags unchanged
// - Decrement-skip with zero result runs a no-operation instead of next word
//
`timescale 1ns/1ns
module cce_exec #(
    parameter int PRE_W = 8
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [cce_pkg::CCE_INSTR_W-1:0] instr_word,
    input wire logic instr_valid,
    input wire logic [cce_pkg::CCE_LATCH_W-1:0] upper_address_latch,
    input wire logic [cce_pkg::CCE_DATA_W-1:0] file_rdata,
    input wire logic wdt_tick,
    output logic [cce_pkg::CCE_PC_W-1:0] prog_addr,
    output logic [cce_pkg::CCE_FADDR_W-1:0] file_raddr,
    output logic [cce_pkg::CCE_FADDR_W-1:0] file_waddr,
    output logic [cce_pkg::CCE_DATA_W-1:0] file_wdata,
    output logic file_we,
    output logic [cce_pkg::CCE_DATA_W-1:0] working_value,
    output logic zero_flag,
    output logic timeout_flag,
    output logic power_down_flag,
    output logic stack_push,
    output logic [cce_pkg::CCE_PC_W-1:0] stack_top,
    output logic [cce_pkg::CCE_WDT_W-1:0] watchdog_counter,
    output logic [PRE_W-1:0] watchdog_prescaler,
    output logic skip_active
);
    import cce_pkg::*;

    // ************************************************************
    // Parameter check
    // ************************************************************
    generate
        if (PRE_W < 1 || PRE_W > 16) begin : g_bad_pre
            $error("PRE_W must lie between 1 and 16");
        end
    endgenerate

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        cce_state_e state;
        logic [CCE_PC_W-1:0] pc;
        logic exec_valid;
        logic [CCE_INSTR_W-1:0] instr;
        logic [CCE_PC_W-1:0] exec_pc;
        logic [CCE_DATA_W-1:0] working;
        logic zero;
        logic timeout;
        logic power_down;
        logic file_we;
        logic [CCE_FADDR_W-1:0] file_waddr;
        logic [CCE_DATA_W-1:0] file_wdata;
        logic stack_push;
        logic [CCE_PC_W-1:0] stack_data;
        logic [CCE_WDT_W-1:0] wdt_count;
        logic [PRE_W-1:0] wdt_pre;
    } cce_st_s;

    localparam cce_st_s RST_VAL = '{
        state: CCE_ST_RUN,
        pc: CCE_PC_RESET,
        timeout: CCE_TIMEOUT_RESET,
        power_down: CCE_POWER_DOWN_RESET,
        default: '0
    };

    cce_st_s st_reg;
    cce_st_s st_next;
    cce_op_e op;
    logic ex_go;
    logic dest_file;
    logic [CCE_DATA_W-1:0] operand;
    logic [CCE_DATA_W-1:0] result;

    cce_op_decode u_decode (
        .instr_word(st_reg.instr),
        .op(op)
    );

    // ************************************************************
    // Operand with bypass of the pending file write
    // ************************************************************
    assign ex_go = st_reg.exec_valid && (st_reg.state == CCE_ST_RUN);
    assign dest_file = st_reg.instr[CCE_DEST_BIT];
    assign operand = (st_reg.file_we && st_reg.file_waddr == st_reg.instr[CCE_FADDR_W-1:0])
        ? st_reg.file_wdata : file_rdata;

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        st_next = st_reg;
        result = CCE_ZERO_BYTE;
        st_next.file_we = 1'b0;
        st_next.stack_push = 1'b0;
        st_next.state = CCE_ST_RUN;
        // Fetch side: word at pc enters execute
        st_next.exec_valid = instr_valid;
        if (instr_valid) begin
            st_next.instr = instr_word;
            st_next.exec_pc = st_reg.pc;
            st_next.pc = st_reg.pc + CCE_PC_STEP;
        end
        // Watchdog prescaler and counter
        if (wdt_tick) begin
            st_next.wdt_pre = st_reg.wdt_pre + 1'b1;
            if (&st_reg.wdt_pre) begin
                st_next.wdt_count = st_reg.wdt_count + 1'b1;
                if (&st_reg.wdt_count) begin
                    st_next.timeout = 1'b0;
                end
            end
        end
        if (ex_go) begin
            case (op)
                CCE_OP_CALL: begin
                    st_next.stack_push = 1'b1;
                    st_next.stack_data = st_reg.exec_pc + CCE_PC_STEP;
                    st_next.pc = {upper_address_latch[CCE_LATCH_HI:CCE_LATCH_LO],
                        st_reg.instr[CCE_LIT_W-1:0]};
                    st_next.state = CCE_ST_NOP;
                end
                CCE_OP_WDTCLR: begin
                    st_next.wdt_count = '0;
                    st_next.wdt_pre = '0;
                    st_next.timeout = 1'b1;
                    st_next.power_down = 1'b1;
                end
                CCE_OP_REGISTER_CLEAR_OP: begin
                    st_next.file_we = 1'b1;
                    st_next.file_waddr = st_reg.instr[CCE_FADDR_W-1:0];
                    st_next.file_wdata = CCE_ZERO_BYTE;
                    st_next.zero = 1'b1;
                end
                CCE_OP_WORKING_CLEAR_OP: begin
                    st_next.working = CCE_ZERO_BYTE;
                    st_next.zero = 1'b1;
                end
                CCE_OP_REGISTER_INVERT_OP, CCE_OP_REGISTER_DECREMENT_OP, CCE_OP_DECREMENT_SKIP_ZERO_OP: begin
                    if (op == CCE_OP_REGISTER_INVERT_OP) begin
                        result = ~operand;
                    end else begin
                        result = operand - CCE_ONE_BYTE;
                    end
                    if (dest_file) begin
                        st_next.file_we = 1'b1;
                        st_next.file_waddr = st_reg.instr[CCE_FADDR_W-1:0];
                        st_next.file_wdata = result;
                    end else begin
                        st_next.working = result;
                    end
                    if (op != CCE_OP_DECREMENT_SKIP_ZERO_OP) begin
                        st_next.zero = (result == CCE_ZERO_BYTE);
                    end else if (result == CCE_ZERO_BYTE) begin
                        st_next.pc = st_reg.exec_pc + CCE_PC_SKIP_STEP;
                        st_next.state = CCE_ST_NOP;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_reg <= RST_VAL;
        end else begin
            st_reg <= st_next;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign prog_addr = st_reg.pc;
    assign file_raddr = st_reg.instr[CCE_FADDR_W-1:0];
    assign file_waddr = st_reg.file_waddr;
    assign file_wdata = st_reg.file_wdata;
    assign file_we = st_reg.file_we;
    assign working_value = st_reg.working;
    assign zero_flag = st_reg.zero;
    assign timeout_flag = st_reg.timeout;
    assign power_down_flag = st_reg.power_down;
    assign stack_push = st_reg.stack_push;
    assign stack_top = st_reg.stack_data;
    assign watchdog_counter = st_reg.wdt_count;
    assign watchdog_prescaler = st_reg.wdt_pre;
    assign skip_active = (st_reg.state == CCE_ST_NOP);

    // ************************************************************
    // Checks
    // ************************************************************
    property p_call_push;
        @(posedge sys_clk) disable iff (rst)
        (ex_go && op == CCE_OP_CALL) |=>
            stack_push && stack_top == $past(st_reg.exec_pc) + CCE_PC_STEP;
    endproperty
    a_call_push: assert property (p_call_push) else $error("call push wrong");

    property p_call_low;
        @(posedge sys_clk) disable iff (rst)
        (ex_go && op == CCE_OP_CALL) |=>
            prog_addr[CCE_LIT_W-1:0] == $past(st_reg.instr[CCE_LIT_W-1:0]);
    endproperty
    a_call_low: assert property (p_call_low) else $error("call target low bits");

    property p_call_high;
        @(posedge sys_clk) disable iff (rst)
        (ex_go && op == CCE_OP_CALL) |=>
            prog_addr[12:11] == $past(upper_address_latch[CCE_LATCH_HI:CCE_LATCH_LO]);
    endproperty
    a_call_high: assert property (p_call_high) else $error("call target high bits");

    property p_call_two;
        @(posedge sys_clk) disable iff (rst)
        (ex_go && op == CCE_OP_CALL) |=>
            skip_active && $stable(zero_flag) && $stable(timeout_flag)
            ##1 !skip_active;
    endproperty
    a_call_two: assert property (p_call_two) else $error("call cycles or flags");

    property p_wdt_zero;
        @(posedge sys_clk) disable iff (rst)
        (ex_go && op == CCE_OP_WDTCLR) |=>
            watchdog_counter == '0 && watchdog_prescaler == '0;
    endproperty
    a_wdt_zero: assert property (p_wdt_zero) else $error("watchdog not cleared");

    property p_wdt_flags;
        @(posedge sys_clk) disable iff (rst)
        (ex_go && op == CCE_OP_WDTCLR) |=> timeout_flag && power_down_flag;
    endproperty
    a_wdt_flags: assert property (p_wdt_flags) else $error("timeout or power flag");

    property p_register_clear_op;
        @(posedge sys_clk) disable iff (rst)
        (ex_go && op == CCE_OP_REGISTER_CLEAR_OP) |=>
            file_we && file_wdata == CCE_ZERO_BYTE && zero_flag
            && file_waddr == $past(st_reg.instr[CCE_FADDR_W-1:0]);
    endproperty
    a_register_clear_op: assert property (p_register_clear_op) else $error("register clear wrong");

    property p_working_clear_op;
        @(posedge sys_clk) disable iff (rst)
        (ex_go && op == CCE_OP_WORKING_CLEAR_OP) |=> working_value == CCE_ZERO_BYTE && zero_flag;
    endproperty
    a_working_clear_op: assert property (p_working_clear_op) else $error("working clear wrong");

    property p_register_invert_op;
        @(posedge sys_clk) disable iff (rst)
        (ex_go && op == CCE_OP_REGISTER_INVERT_OP && dest_file) |=>
            file_we && file_wdata == ~$past(operand);
    endproperty
    a_register_invert_op: assert property (p_register_invert_op) else $error("invert result wrong");

    property p_register_decrement_op;
        @(posedge sys_clk) disable iff (rst)
        (ex_go && op == CCE_OP_REGISTER_DECREMENT_OP && !dest_file) |=>
            !file_we && working_value == $past(operand) - CCE_ONE_BYTE;
    endproperty
    a_register_decrement_op: assert property (p_register_decrement_op) else $error("decrement result wrong");

    property p_decrement_skip_zero_op_flags;
        @(posedge sys_clk) disable iff (rst)
        (ex_go && op == CCE_OP_DECREMENT_SKIP_ZERO_OP) |=> $stable(zero_flag);
    endproperty
    a_decrement_skip_zero_op_flags: assert property (p_decrement_skip_zero_op_flags) else $error("skip op changed flag");

    property p_decrement_skip_zero_op_skip;
        @(posedge sys_clk) disable iff (rst)
        (ex_go && op == CCE_OP_DECREMENT_SKIP_ZERO_OP) |=>
            skip_active == ($past(operand) == CCE_ONE_BYTE);
    endproperty
    a_decrement_skip_zero_op_skip: assert property (p_decrement_skip_zero_op_skip) else $error("skip decision wrong");

    property p_zero;
        @(posedge sys_clk) disable iff (rst)
        (ex_go && op == CCE_OP_REGISTER_DECREMENT_OP && dest_file) |=>
            zero_flag == (file_wdata == CCE_ZERO_BYTE);
    endproperty
    a_zero: assert property (p_zero) else $error("zero flag mismatch");

    property p_register_invert_op_work;
        @(posedge sys_clk) disable iff (rst)
        (ex_go && op == CCE_OP_REGISTER_INVERT_OP && !dest_file) |=>
            !file_we && working_value == ~$past(operand);
    endproperty
    a_register_invert_op_work: assert property (p_register_invert_op_work) else $error("invert to working wrong");

    property p_zero_register_invert_op;
        @(posedge sys_clk) disable iff (rst)
        (ex_go && op == CCE_OP_REGISTER_INVERT_OP) |=>
            zero_flag == (~$past(operand) == CCE_ZERO_BYTE);
    endproperty
    a_zero_register_invert_op: assert property (p_zero_register_invert_op) else $error("invert zero flag");

    property p_register_decrement_op_file;
        @(posedge sys_clk) disable iff (rst)
        (ex_go && op == CCE_OP_REGISTER_DECREMENT_OP && dest_file) |=>
            file_we && file_wdata == $past(operand) - CCE_ONE_BYTE
            && file_waddr == $past(st_reg.instr[CCE_FADDR_W-1:0]);
    endproperty
    a_register_decrement_op_file: assert property (p_register_decrement_op_file) else $error("decrement to file wrong");

    property p_decrement_skip_zero_op_file;
        @(posedge sys_clk) disable iff (rst)
        (ex_go && op == CCE_OP_DECREMENT_SKIP_ZERO_OP && dest_file) |=>
            file_we && file_wdata == $past(operand) - CCE_ONE_BYTE;
    endproperty
    a_decrement_skip_zero_op_file: assert property (p_decrement_skip_zero_op_file) else $error("skip op file value");

    property p_decrement_skip_zero_op_work;
        @(posedge sys_clk) disable iff (rst)
        (ex_go && op == CCE_OP_DECREMENT_SKIP_ZERO_OP && !dest_file) |=>
            !file_we && working_value == $past(operand) - CCE_ONE_BYTE;
    endproperty
    a_decrement_skip_zero_op_work: assert property (p_decrement_skip_zero_op_work) else $error("skip op working");

    property p_skip_pc;
        @(posedge sys_clk) disable iff (rst)
        (ex_go && op == CCE_OP_DECREMENT_SKIP_ZERO_OP && operand == CCE_ONE_BYTE) |=>
            prog_addr == $past(st_reg.exec_pc) + CCE_PC_SKIP_STEP;
    endproperty
    a_skip_pc: assert property (p_skip_pc) else $error("skip address wrong");

    property p_skip_quiet;
        @(posedge sys_clk) disable iff (rst)
        skip_active |=> !file_we && !stack_push
            && $stable(working_value) && $stable(zero_flag);
    endproperty
    a_skip_quiet: assert property (p_skip_quiet) else $error("discarded word acted");

    property p_call_quiet;
        @(posedge sys_clk) disable iff (rst)
        (ex_go && op == CCE_OP_CALL) |=>
            !file_we && $stable(working_value) && $stable(power_down_flag);
    endproperty
    a_call_quiet: assert property (p_call_quiet) else $error("call touched data");

endmodule // cce_exec

//--- rtl/cce_pkg.sv
// Shared constants and types for the call, clear and decrement execution block
package cce_pkg;

    // ************************************************************
    // Widths
    // ************************************************************
    localparam int CCE_INSTR_W = 14;
    localparam int CCE_PC_W = 13;
    localparam int CCE_DATA_W = 8;
    localparam int CCE_FADDR_W = 7;
    localparam int CCE_LIT_W = 11;
    localparam int CCE_LATCH_W = 8;
    localparam int CCE_WDT_W = 8;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int CCE_DEST_BIT = 7;
    localparam int CCE_LATCH_HI = 4;
    localparam int CCE_LATCH_LO = 3;

    // ************************************************************
    // Opcode match values and masks
    // ************************************************************
    localparam logic [13:0] CCE_MASK_CALL = 14'h3800;
    localparam logic [13:0] CCE_CODE_CALL = 14'h2000;
    localparam logic [13:0] CCE_CODE_WDTCLR = 14'h0064;
    localparam logic [13:0] CCE_MASK_CLR = 14'h3F80;
    localparam logic [13:0] CCE_CODE_REGISTER_CLEAR_OP = 14'h0180;
    localparam logic [13:0] CCE_CODE_WORKING_CLEAR_OP = 14'h0100;
    localparam logic [13:0] CCE_MASK_FD = 14'h3F00;
    localparam logic [13:0] CCE_CODE_REGISTER_INVERT_OP = 14'h0900;
    localparam logic [13:0] CCE_CODE_REGISTER_DECREMENT_OP = 14'h0300;
    localparam logic [13:0] CCE_CODE_DECREMENT_SKIP_ZERO_OP = 14'h0B00;

    // ************************************************************
    // Reset values and counts
    // ************************************************************
    localparam logic [12:0] CCE_PC_RESET = 13'h0000;
    localparam logic CCE_TIMEOUT_RESET = 1'b1;
    localparam logic CCE_POWER_DOWN_RESET = 1'b1;
    localparam logic [7:0] CCE_ZERO_BYTE = 8'h00;
    localparam logic [12:0] CCE_PC_STEP = 13'h0001;
    localparam logic [12:0] CCE_PC_SKIP_STEP = 13'h0002;
    localparam logic [7:0] CCE_ONE_BYTE = 8'h01;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [2:0] {
        CCE_OP_OTHER = 3'h0,
        CCE_OP_CALL = 3'h1,
        CCE_OP_WDTCLR = 3'h2,
        CCE_OP_REGISTER_CLEAR_OP = 3'h3,
        CCE_OP_WORKING_CLEAR_OP = 3'h4,
        CCE_OP_REGISTER_INVERT_OP = 3'h5,
        CCE_OP_REGISTER_DECREMENT_OP = 3'h6,
        CCE_OP_DECREMENT_SKIP_ZERO_OP = 3'h7
    } cce_op_e;

    typedef enum logic {
        CCE_ST_RUN = 1'b0,
        CCE_ST_NOP = 1'b1
    } cce_state_e;

endpackage

//--- rtl/cce_op_decode.sv
// Opcode classifier for the execution block
`timescale 1ns/1ns
module cce_op_decode (
    input wire logic [cce_pkg::CCE_INSTR_W-1:0] instr_word,
    output cce_pkg::cce_op_e op
);
    import cce_pkg::*;

    // ************************************************************
    // Match in priority order
    // ************************************************************
    always_comb begin
        if ((instr_word & CCE_MASK_CALL) == CCE_CODE_CALL) begin
            op = CCE_OP_CALL;
        end else if (instr_word == CCE_CODE_WDTCLR) begin
            op = CCE_OP_WDTCLR;
        end else if ((instr_word & CCE_MASK_CLR) == CCE_CODE_REGISTER_CLEAR_OP) begin
            op = CCE_OP_REGISTER_CLEAR_OP;
        end else if ((instr_word & CCE_MASK_CLR) == CCE_CODE_WORKING_CLEAR_OP) begin
            op = CCE_OP_WORKING_CLEAR_OP;
        end else if ((instr_word & CCE_MASK_FD) == CCE_CODE_REGISTER_INVERT_OP) begin
            op = CCE_OP_REGISTER_INVERT_OP;
        end else if ((instr_word & CCE_MASK_FD) == CCE_CODE_REGISTER_DECREMENT_OP) begin
            op = CCE_OP_REGISTER_DECREMENT_OP;
        end else if ((instr_word & CCE_MASK_FD) == CCE_CODE_DECREMENT_SKIP_ZERO_OP) begin
            op = CCE_OP_DECREMENT_SKIP_ZERO_OP;
        end else begin
            op = CCE_OP_OTHER;
        end
    end

endmodule // cce_op_decode

//--- verification/cce_exec_tb_top.sv
// Self-checking testbench for the call, clear and decrement execution block
`timescale 1ns/1ns
module cce_exec_tb_top;
    import cce_pkg::*;
    localparam int PRE_W = 2;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [CCE_INSTR_W-1:0] instr_word = 14'h0000;
    logic instr_valid = 1'b0;
    logic [CCE_LATCH_W-1:0] upper_address_latch = 8'h00;
    logic [CCE_DATA_W-1:0] file_rdata;
    logic wdt_tick = 1'b0;
    logic [CCE_PC_W-1:0] prog_addr;
    logic [CCE_FADDR_W-1:0] file_raddr;
    logic [CCE_FADDR_W-1:0] file_waddr;
    logic [CCE_DATA_W-1:0] file_wdata;
    logic file_we;
    logic [CCE_DATA_W-1:0] working_value;
    logic zero_flag;
    logic timeout_flag;
    logic power_down_flag;
    logic stack_push;
    logic [CCE_PC_W-1:0] stack_top;
    logic [CCE_WDT_W-1:0] watchdog_counter;
    logic [PRE_W-1:0] watchdog_prescaler;
    logic skip_active;
    logic [7:0] fmem [128];
    logic [7:0] emem [128];
    logic [12:0] top_seen = 13'h0000;
    logic [12:0] e_top = 13'h0000;
    int pc, w, z, to, pd, n_tick, n_push, n_skip, e_push, e_skip;
    int n_mismatch = 0;
    int compares = 0;

    // ************************************************************
    // Clock, file register model and pulse monitor
    // ************************************************************
    always #20 sys_clk = ~sys_clk;

    assign file_rdata = fmem[file_raddr];

    always @(posedge sys_clk) begin
        if (file_we === 1'b1) fmem[file_waddr] <= file_wdata;
        if (!rst && stack_push === 1'b1) begin
            n_push++;
            top_seen = stack_top;
        end
        if (!rst && skip_active === 1'b1) n_skip++;
    end

    cce_exec #(.PRE_W(PRE_W)) uut (
        .sys_clk(sys_clk),
        .rst(rst),
        .instr_word(instr_word),
        .instr_valid(instr_valid),
        .upper_address_latch(upper_address_latch),
        .file_rdata(file_rdata),
        .wdt_tick(wdt_tick),
        .prog_addr(prog_addr),
        .file_raddr(file_raddr),
        .file_waddr(file_waddr),
        .file_wdata(file_wdata),
        .file_we(file_we),
        .working_value(working_value),
        .zero_flag(zero_flag),
        .timeout_flag(timeout_flag),
        .power_down_flag(power_down_flag),
        .stack_push(stack_push),
        .stack_top(stack_top),
        .watchdog_counter(watchdog_counter),
        .watchdog_prescaler(watchdog_prescaler),
        .skip_active(skip_active)
    );

    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t ns: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic stop_test;
        $display("Comparisons %0d, mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic put(input logic [13:0] word, input logic valid);
        @(posedge sys_clk);
        instr_word <= word;
        instr_valid <= valid;
    endtask

    // Issue one word, optionally followed back to back by a working clear
    task automatic step(input logic [13:0] iw, input logic pair);
        int r;
        int a;
        int f;
        logic skip;
        r = -1;
        a = pc;
        f = iw[6:0];
        skip = 1'b0;
        put(iw, 1'b1);
        if (pair) put(CCE_CODE_WORKING_CLEAR_OP, 1'b1);
        pc = (pc + 1 + pair) & 13'h1FFF;
        if ((iw & CCE_MASK_CALL) == CCE_CODE_CALL) begin
            e_top = 13'((a + 1) & 13'h1FFF);
            pc = {upper_address_latch[4:3], iw[10:0]};
            e_push++;
            skip = 1'b1;
        end else if (iw == CCE_CODE_WDTCLR) begin
            to = 1;
            pd = 1;
        end else if ((iw & CCE_MASK_CLR) == CCE_CODE_REGISTER_CLEAR_OP) begin
            emem[f] = 8'h00;
            z = 1;
        end else if ((iw & CCE_MASK_CLR) == CCE_CODE_WORKING_CLEAR_OP) begin
            w = 0;
            z = 1;
        end else if ((iw & CCE_MASK_FD) == CCE_CODE_REGISTER_INVERT_OP) begin
            r = ~emem[f] & 8'hFF;
            z = (r == 0);
        end else if ((iw & CCE_MASK_FD) == CCE_CODE_REGISTER_DECREMENT_OP) begin
            r = (emem[f] - 1) & 8'hFF;
            z = (r == 0);
        end else if ((iw & CCE_MASK_FD) == CCE_CODE_DECREMENT_SKIP_ZERO_OP) begin
            r = (emem[f] - 1) & 8'hFF;
            skip = (r == 0);
        end
        if (r >= 0 && iw[7]) emem[f] = 8'(r);
        if (r >= 0 && !iw[7]) w = r;
        if (skip) e_skip++;
        if (pair && !skip) begin
            w = 0;
            z = 1;
        end
        repeat (3) put(14'h0000, 1'b0);
        #1;
        check(prog_addr, pc, "prog_addr");
        check(working_value, w, "working");
        check(zero_flag, z, "zero flag");
        check(timeout_flag, to, "timeout");
        check(power_down_flag, pd, "power down");
        check(n_push, e_push, "push count");
        check(top_seen, e_top, "return address");
        check(n_skip, e_skip, "skip count");
        for (int i = 0; i < 128; i++) check(fmem[i], emem[i], "file");
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        logic [6:0] fv;
        logic dv;
        logic t;
        pc = $urandom(51610);
        pc = 0;
        w = 0;
        z = 0;
        to = 1;
        pd = 1;
        n_tick = 0;
        n_push = 0;
        n_skip = 0;
        e_push = 0;
        e_skip = 0;
        for (int i = 0; i < 128; i++) begin
            fmem[i] = 8'($urandom);
            emem[i] = fmem[i];
        end
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        #1;
        check(prog_addr, 16'h0000, "reset pc");
        check(timeout_flag, 16'h0001, "reset timeout");
        // Watchdog advance under random ticks
        for (int i = 0; i < 2000; i++) begin
            @(posedge sys_clk);
            t = ($urandom % 4) != 0;
            wdt_tick <= t;
            n_tick += t;
        end
        @(posedge sys_clk);
        wdt_tick <= 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
        to = (n_tick >= (1 << (PRE_W + CCE_WDT_W))) ? 0 : 1;
        check(watchdog_counter, (n_tick >> PRE_W) % (1 << CCE_WDT_W), "wdt counter");
        check(watchdog_prescaler, n_tick % (1 << PRE_W), "wdt prescaler");
        check(timeout_flag, to, "wdt timeout");
        // Fixed rotation through the instruction group with random and boundary operands
        for (int i = 0; i < 60; i++) begin
            fv = (i < 4) ? ((i % 2) ? 7'h7F : 7'h00) : 7'($urandom);
            dv = 1'($urandom);
            case ($urandom % 4)
                0: fmem[fv] = 8'h00;
                1: fmem[fv] = 8'h01;
                2: fmem[fv] = 8'hFF;
                default: fmem[fv] = 8'($urandom);
            endcase
            emem[fv] = fmem[fv];
            @(posedge sys_clk);
            upper_address_latch <= 8'($urandom);
            case (i % 6)
                0: step(CCE_CODE_REGISTER_CLEAR_OP | {7'h00, fv}, 1'b0);
                1: step(CCE_CODE_WORKING_CLEAR_OP | {7'h00, fv}, 1'b0);
                2: step(CCE_CODE_REGISTER_INVERT_OP | {6'h00, dv, fv}, 1'b0);
                3: step(CCE_CODE_REGISTER_DECREMENT_OP | {6'h00, dv, fv}, 1'b0);
                4: step(CCE_CODE_DECREMENT_SKIP_ZERO_OP | {6'h00, dv, fv}, 1'b1);
                default: step(CCE_CODE_CALL | {3'h0, (i == 5) ? 11'h000 :
                    (i == 11) ? 11'h7FF : 11'($urandom)}, 1'b1);
            endcase
        end
        // Word outside the group does nothing
        step(14'h0000, 1'b1);
        // Watchdog clear
        step(CCE_CODE_WDTCLR, 1'b0);
        check(watchdog_counter, 16'h0000, "wdt cleared");
        check(watchdog_prescaler, 16'h0000, "prescaler cleared");
        stop_test();
    end

    initial begin
        #(40 * 20000);
        n_mismatch++;
        stop_test();
    end
endmodule // cce_exec_tb_top
